// ### inc/csl_regs.svh
// timing counts and factory network defaults for the config stick loader
// assumes a 25 MHz system clock; power cycling is the reset
`ifndef CSL_REGS_SVH
`define CSL_REGS_SVH
`define CSL_CLK_HZ 32'h017D7840
`define CSL_WINDOW_S 32'h00000003
`define CSL_WINDOW_CYC (`CSL_CLK_HZ * `CSL_WINDOW_S)
`define CSL_SLOW_HALF_CYC 32'h005F5E10
`define CSL_FAST_HALF_CYC 32'h0017D784
`define CSL_DEF_IP 32'hC0A80080
`define CSL_DEF_MASK 32'hFFFFFF00
`define CSL_DEF_GW 32'h00000000
`define CSL_DEF_PORT 16'h01F6
`define CSL_DEF_AUTONEG 1'b1
`endif

// ### inc/csl_pkg.sv
// types for the config stick loader
// no surroundings assumed
package csl_pkg;
  typedef enum logic [2:0] {
    CSL_WAIT_CFG = 3'h0,
    CSL_LOAD_FLASH = 3'h1,
    CSL_CYCLE_PWR = 3'h2,
    CSL_IDLE_CFG = 3'h3,
    CSL_MATCH_FLASH = 3'h4,
    CSL_MATCH_DONE = 3'h5,
    CSL_MISMATCH = 3'h6,
    CSL_LOCKOUT = 3'h7
  } csl_state_t;
  typedef enum logic [1:0] {
    CSL_OFF = 2'h0,
    CSL_GREEN = 2'h1,
    CSL_RED = 2'h2
  } csl_color_t;
endpackage

// ### src/csl_loader.sv
// config stick loader: stick detection, download, compare, lockout, factory restore
// assumes stick sense and compare results are synchronous and valid while stick_present is high
`include "csl_regs.svh"

// Behaviour
// - unconfigured: power green steady, usb green flash
// - configured, no stick: power green, usb red
// - insertion unconfigured: usb fast flash 3 s, steady
// - unconfigured device copies stick contents automatically
// - after download, power green flashes for cycle
// - match: usb green flash 3 s, steady
// - net differs, unlocked: write net after 3 s
// - net differs, locked: enter lockout
// - config or password mismatch: usb flashes red
// - mismatch, no removal in 3 s: lockout
// - after power cycle usb shows stick presence
// - factory restore only after password verified
// - factory network defaults fixed values
module csl_loader #(
  parameter int unsigned WINDOW_CYC = `CSL_WINDOW_CYC,
  parameter int unsigned SLOW_HALF = `CSL_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = `CSL_FAST_HALF_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic configured,
  input wire logic stick_present,
  input wire logic stick_locked,
  input wire logic cfg_match,
  input wire logic pwd_match,
  input wire logic net_match,
  input wire logic factory_req,
  input wire logic primary_user_password_ok,
  output logic copy_to_device,
  output logic copy_net_to_stick,
  output logic factory_restore,
  output logic [31:0] def_ip,
  output logic [31:0] def_mask,
  output logic [31:0] def_gw,
  output logic [15:0] def_port,
  output logic def_autoneg,
  output logic lockout,
  output logic [1:0] pwr_led,
  output logic [1:0] usb_led
);
  // ===========================================================
  // state
  typedef struct packed {
    csl_pkg::csl_state_t st;
    logic [31:0] win;
    logic [31:0] blink;
    logic slow;
    logic fast;
    logic copy;
    logic netw;
    logic fac;
    logic net_done;
    logic [1:0] pwr;
    logic [1:0] usb;
    logic started;
  } csl_reg_t;

  csl_reg_t q, d;
  logic win_done;

  assign win_done = (q.win >= WINDOW_CYC - 1);

  // one flash phase of a colour; shared by every flashing indicator
  function automatic logic [1:0] flash_of(input logic on, input logic [1:0] colour);
    return on ? colour : csl_pkg::CSL_OFF;
  endfunction

  // ===========================================================
  // sequencing and indicators
  always_comb begin
    d = q;
    d.copy = 1'b0;
    d.netw = 1'b0;
    d.fac = 1'b0;
    // free-running blink dividers; fast toggles at a quarter of the slow period
    d.blink = q.blink + 32'h1;
    if (q.blink % FAST_HALF == FAST_HALF - 1) begin
      d.fast = ~q.fast;
    end
    if (q.blink >= SLOW_HALF - 1) begin
      d.blink = 32'h0;
      d.slow = ~q.slow;
    end
    d.win = win_done ? q.win : q.win + 32'h1;
    // restore needs the password check in the same cycle as the request
    if (factory_req && primary_user_password_ok) begin
      d.fac = 1'b1;
    end
    unique case (q.st)
      csl_pkg::CSL_WAIT_CFG: begin
        if (stick_present) begin
          d.st = csl_pkg::CSL_LOAD_FLASH;
          d.win = 32'h0;
        end
      end
      csl_pkg::CSL_LOAD_FLASH: begin
        // a stick pulled mid-flash leaves nothing valid to copy, so wait again
        if (!stick_present) begin
          d.st = csl_pkg::CSL_WAIT_CFG;
        end else if (win_done) begin
          d.st = csl_pkg::CSL_CYCLE_PWR;
          d.copy = 1'b1;
        end
      end
      csl_pkg::CSL_CYCLE_PWR: begin
        // stays until power is cycled, stick events ignored
        d.st = csl_pkg::CSL_CYCLE_PWR;
      end
      csl_pkg::CSL_IDLE_CFG: begin
        if (stick_present) begin
          d.win = 32'h0;
          d.st = (cfg_match && pwd_match) ? csl_pkg::CSL_MATCH_FLASH : csl_pkg::CSL_MISMATCH;
        end
      end
      csl_pkg::CSL_MATCH_FLASH: begin
        // compare lines mean nothing once the stick is gone; never act on them
        if (!stick_present) begin
          d.st = csl_pkg::CSL_IDLE_CFG;
        end else if (win_done) begin
          d.st = csl_pkg::CSL_MATCH_DONE;
          if (!net_match && stick_locked) begin
            d.st = csl_pkg::CSL_LOCKOUT;
          end else if (!net_match) begin
            d.netw = 1'b1;
          end
        end
      end
      csl_pkg::CSL_MATCH_DONE: begin
        if (!stick_present) begin
          d.st = csl_pkg::CSL_IDLE_CFG;
        end
      end
      csl_pkg::CSL_MISMATCH: begin
        if (!stick_present) begin
          d.st = csl_pkg::CSL_IDLE_CFG;
        end else if (win_done) begin
          d.st = csl_pkg::CSL_LOCKOUT;
        end
      end
      csl_pkg::CSL_LOCKOUT: begin
        d.st = csl_pkg::CSL_LOCKOUT;
      end
    endcase
    // indicator colours
    d.pwr = csl_pkg::CSL_GREEN;
    d.usb = stick_present ? csl_pkg::CSL_GREEN : csl_pkg::CSL_RED;
    unique case (d.st)
      csl_pkg::CSL_WAIT_CFG: d.usb = flash_of(d.slow, csl_pkg::CSL_GREEN);
      csl_pkg::CSL_LOAD_FLASH: d.usb = flash_of(d.fast, csl_pkg::CSL_GREEN);
      csl_pkg::CSL_CYCLE_PWR: begin
        d.usb = csl_pkg::CSL_GREEN;
        d.pwr = flash_of(d.slow, csl_pkg::CSL_GREEN);
      end
      csl_pkg::CSL_IDLE_CFG: ; // usb follows stick presence, set above
      csl_pkg::CSL_MATCH_FLASH: d.usb = flash_of(d.slow, csl_pkg::CSL_GREEN);
      csl_pkg::CSL_MATCH_DONE: d.usb = csl_pkg::CSL_GREEN;
      csl_pkg::CSL_MISMATCH: d.usb = flash_of(d.slow, csl_pkg::CSL_RED);
      csl_pkg::CSL_LOCKOUT: begin
        d.usb = flash_of(d.slow, csl_pkg::CSL_RED);
        d.pwr = d.usb;
      end
    endcase
    // first edge after release: the start state follows the configured level
    if (!q.started) begin
      d = '0;
      d.started = 1'b1;
      d.st = configured ? csl_pkg::CSL_IDLE_CFG : csl_pkg::CSL_WAIT_CFG;
      d.win = WINDOW_CYC;
      d.pwr = csl_pkg::CSL_GREEN;
    end
  end

  // ===========================================================
  // register; power cycling clears everything, the start state is loaded one edge later
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign copy_to_device = q.copy;
  assign copy_net_to_stick = q.netw;
  assign factory_restore = q.fac;
  assign lockout = (q.st == csl_pkg::CSL_LOCKOUT);
  assign pwr_led = q.pwr;
  assign usb_led = q.usb;
  // factory defaults, active after the next power cycle
  assign def_ip = `CSL_DEF_IP;
  assign def_mask = `CSL_DEF_MASK;
  assign def_gw = `CSL_DEF_GW;
  assign def_port = `CSL_DEF_PORT;
  assign def_autoneg = `CSL_DEF_AUTONEG;

  // ===========================================================
  // checks
  a_restore_pwd: assert property (@(posedge clock) disable iff (!arst_n)
    factory_restore |-> ($past(primary_user_password_ok) && $past(factory_req)))
    else $error("restore without password");
  a_lock_stays: assert property (@(posedge clock) disable iff (!arst_n)
    lockout |=> lockout) else $error("lockout left");
  a_copy_once: assert property (@(posedge clock) disable iff (!arst_n)
    copy_to_device |=> !copy_to_device [*8]) else $error("copy repeated");
  a_lock_leds: assert property (@(posedge clock) disable iff (!arst_n)
    lockout |=> (usb_led != csl_pkg::CSL_GREEN && pwr_led != csl_pkg::CSL_GREEN)) else $error("lock led");
  a_lock_pair: assert property (@(posedge clock) disable iff (!arst_n)
    lockout |-> pwr_led == usb_led) else $error("lock leds not flashing together");
  a_nostick_red: assert property (@(posedge clock) disable iff (!arst_n)
    (q.st == csl_pkg::CSL_IDLE_CFG && !stick_present && q.started) |=> usb_led == csl_pkg::CSL_RED)
    else $error("usb not red");
  a_net_locked: assert property (@(posedge clock) disable iff (!arst_n)
    copy_net_to_stick |-> !$past(stick_locked)) else $error("locked stick written");
  a_mis_red: assert property (@(posedge clock) disable iff (!arst_n)
    q.st == csl_pkg::CSL_MISMATCH |-> usb_led != csl_pkg::CSL_GREEN) else $error("mismatch green");
  a_wait_pwr: assert property (@(posedge clock) disable iff (!arst_n)
    (q.started && q.st == csl_pkg::CSL_WAIT_CFG) |-> pwr_led == csl_pkg::CSL_GREEN)
    else $error("power not green");
  a_load_steady: assert property (@(posedge clock) disable iff (!arst_n)
    q.st == csl_pkg::CSL_CYCLE_PWR |-> usb_led == csl_pkg::CSL_GREEN) else $error("usb not steady after load");
  a_match_steady: assert property (@(posedge clock) disable iff (!arst_n)
    q.st == csl_pkg::CSL_MATCH_DONE |-> usb_led == csl_pkg::CSL_GREEN) else $error("usb not steady after match");
  c_download: cover property (@(posedge clock) disable iff (!arst_n) copy_to_device);
  c_lockout: cover property (@(posedge clock) disable iff (!arst_n) $rose(lockout));
  c_netw: cover property (@(posedge clock) disable iff (!arst_n) copy_net_to_stick);
  c_early_pull: cover property (@(posedge clock) disable iff (!arst_n)
    q.st == csl_pkg::CSL_MISMATCH && !stick_present);
endmodule

// ### dv/csl_stick.sv
// removable config stick model: sense and compare lines seen by the loader
// assumes the bench changes plugged and contents at the falling edge
module csl_stick (
  input wire logic clock,
  input wire logic plugged,
  input wire logic [3:0] contents,
  output logic stick_present,
  output logic stick_locked,
  output logic cfg_match,
  output logic pwd_match,
  output logic net_match
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // detached lines
  logic churn_q = 1'b0;
  // a removed stick drives nothing, so the compare lines churn instead of holding a stale value
  always @(posedge clock) churn_q <= ~churn_q;
  assign stick_present = plugged;
  // contents are the stick image only while plugged: {locked, cfg, pwd, net}
  assign {stick_locked, cfg_match, pwd_match, net_match} = plugged ? contents : {4{churn_q}};
endmodule

// ### dv/tb.sv
// self-checking bench for the config stick loader
// assumes short timing parameters and the stick model on the sense lines
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned W = 20;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic configured = 1'b0;
  logic plugged = 1'b0;
  logic [3:0] contents = 4'h0;
  logic factory_req = 1'b0;
  logic primary_user_password_ok = 1'b0;
  logic stick_present, stick_locked, cfg_match, pwd_match, net_match;
  logic copy_to_device, copy_net_to_stick, factory_restore, def_autoneg, lockout;
  logic [31:0] def_ip, def_mask, def_gw;
  logic [15:0] def_port;
  logic [1:0] pwr_led, usb_led;
  logic [3:0] pm, um, outs;
  logic hit;
  int err_count = 0;
  int samples_checked = 0;
  // 40 ns period
  always #20 clock = ~clock;
  assign outs = {factory_restore, lockout, copy_net_to_stick, copy_to_device};
  csl_stick u_csl_stick (.clock(clock), .plugged(plugged), .contents(contents), .stick_present(stick_present),
    .stick_locked(stick_locked), .cfg_match(cfg_match), .pwd_match(pwd_match), .net_match(net_match));
  csl_loader #(.WINDOW_CYC(W), .SLOW_HALF(4), .FAST_HALF(2)) u_csl_loader (.clock(clock), .arst_n(arst_n),
    .configured(configured), .stick_present(stick_present), .stick_locked(stick_locked), .cfg_match(cfg_match),
    .pwd_match(pwd_match), .net_match(net_match), .factory_req(factory_req),
    .primary_user_password_ok(primary_user_password_ok), .copy_to_device(copy_to_device),
    .copy_net_to_stick(copy_net_to_stick), .factory_restore(factory_restore), .def_ip(def_ip),
    .def_mask(def_mask), .def_gw(def_gw), .def_port(def_port), .def_autoneg(def_autoneg), .lockout(lockout),
    .pwr_led(pwr_led), .usb_led(usb_led));
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // power cycle; configured is settled before release because it is sampled at the first edge
  task automatic power_up(input logic cfg);
    arst_n = 1'b0;
    configured = cfg;
    plugged = 1'b0;
    cyc(20);
    arst_n = 1'b1;
    cyc(2);
  endtask
  // masks: bit n set once a led showed colour n; hit catches any pulse or lockout
  task automatic watch(input int n);
    pm = 4'h0;
    um = 4'h0;
    hit = 1'b0;
    repeat (n) begin
      cyc(1);
      pm[pwr_led] = 1'b1;
      um[usb_led] = 1'b1;
      hit |= |outs;
    end
  endtask
  // bounded wait for one output; running out ends the run
  task automatic wait_hi(input int sel, input int lim);
    int n;
    n = 0;
    while (outs[sel] !== 1'b1) begin
      if (n == lim) begin
        err_count++;
        $display("ERROR %0t: output %0d never rose", $time, sel);
        report_and_stop();
      end
      cyc(1);
      n++;
    end
    samples_checked++;
  endtask
  // scenarios: download, match, locked stick, mismatch, early removal, factory restore
  initial begin
    power_up(1'b0);
    watch(10);
    `CHK(pm, 4'h2)
    `CHK(um, 4'h3)
    plugged = 1'b1;
    watch(W - 4);
    `CHK(um, 4'h3)
    wait_hi(0, 10);
    watch(12);
    `CHK(pm, 4'h3)
    `CHK(um, 4'h2)
    plugged = 1'b0;
    cyc(3);
    plugged = 1'b1;
    watch(W + 5);
    `CHK(hit, 1'b0)
    power_up(1'b1);
    watch(8);
    `CHK(pm, 4'h2)
    `CHK(um, 4'h4)
    contents = 4'h6;
    plugged = 1'b1;
    watch(W - 4);
    `CHK(um, 4'h3)
    `CHK(hit, 1'b0)
    wait_hi(1, 10);
    watch(8);
    `CHK(um, 4'h2)
    power_up(1'b1);
    contents = 4'hE;
    plugged = 1'b1;
    wait_hi(2, W + 6);
    // a locked stick must not be written in the cycle that locks out
    `CHK(outs, 4'h4)
    power_up(1'b1);
    contents = 4'h2;
    plugged = 1'b1;
    watch(W - 4);
    `CHK(um, 4'h5)
    wait_hi(2, 10);
    watch(8);
    `CHK(pm, 4'h5)
    `CHK(um, 4'h5)
    plugged = 1'b0;
    cyc(4);
    `CHK(lockout, 1'b1)
    power_up(1'b1);
    contents = 4'h5;
    plugged = 1'b1;
    watch(10);
    `CHK(um, 4'h5)
    plugged = 1'b0;
    watch(W + 5);
    `CHK(hit, 1'b0)
    factory_req = 1'b1;
    watch(1);
    factory_req = 1'b0;
    watch(3);
    `CHK(hit, 1'b0)
    factory_req = 1'b1;
    primary_user_password_ok = 1'b1;
    cyc(1);
    factory_req = 1'b0;
    primary_user_password_ok = 1'b0;
    wait_hi(3, 2);
    `CHK({def_ip, def_mask, def_gw}, {32'hC0A80080, 32'hFFFFFF00, 32'h00000000})
    `CHK({def_port, def_autoneg}, {16'h01F6, 1'b1})
    // stick inserted after a power cycle, fully matching: no write, usb settles green
    power_up(1'b1);
    contents = 4'h7;
    plugged = 1'b1;
    watch(W + 4);
    `CHK(hit, 1'b0)
    watch(4);
    `CHK(pm, 4'h2)
    `CHK(um, 4'h2)
    report_and_stop();
  end
endmodule
